// *** stf_bus_if.sv ***
// Register bus between the host controller and the transcoder.
`timescale 1ns/1ps
interface stf_bus_if;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;

  modport codec (input addr, input wdata, input wr, input rd, output rdata);
  modport host  (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// *** stf_checker.sv ***
// Concurrent checks on the register bus that joins the host end and the transcoder end.
`timescale 1ns/1ps
module stf_checker
  import stf_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [15:0] rdata
);
  logic       frame_in_q;
  logic       have_fmt_q;
  logic [1:0] type_q;
  logic [4:0] cnt_q;
  logic [4:0] len_w;
  logic       fmt_wr;
  logic       byte_wr;

  assign fmt_wr  = wr && (addr == ADDR_IN_FMT);
  assign byte_wr = wr && (addr == ADDR_IN_BYTE);
  assign len_w   = (type_q == TYPE_VOICE_HI) ? LEN_VOICE_HI : (type_q == TYPE_VOICE_LO) ? LEN_VOICE_LO : LEN_SID;

  // Byte counts only mean something once the input coding is frame based.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      frame_in_q <= 1'b0;
      have_fmt_q <= 1'b0;
      type_q     <= 2'h0;
      cnt_q      <= 5'h00;
    end else begin
      if (wr && (addr == ADDR_IN_SEL)) begin
        frame_in_q <= (wdata[1:0] == CODE_FRAME);
      end
      if (fmt_wr) begin
        have_fmt_q <= 1'b1;
        type_q     <= wdata[1:0];
        cnt_q      <= 5'h00;
      end else if (byte_wr) begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_strobes_apart;
    !(wr && rd);
  endproperty
  a_strobes_apart: assert property (p_strobes_apart) else $error("read and write strobes together");
  property p_rdata_after_read;
    !$past(rd) |-> rdata == 16'h0000;
  endproperty
  a_rdata_after_read: assert property (p_rdata_after_read) else $error("read data outside its cycle");
  property p_in_fmt_reserved;
    fmt_wr |-> (wdata & 16'hFFEC) == 16'h0000;
  endproperty
  a_in_fmt_reserved: assert property (p_in_fmt_reserved) else $error("input format reserved bits set");
  property p_out_fmt_reserved;
    rd && (addr == ADDR_OUT_FMT) |=> (rdata & 16'hFFEC) == 16'h0000;
  endproperty
  a_out_fmt_reserved: assert property (p_out_fmt_reserved) else $error("output format reserved bits set");
  property p_out_no_err;
    rd && (addr == ADDR_OUT_FMT) |=> !rdata[FMT_ERR_BIT];
  endproperty
  a_out_no_err: assert property (p_out_no_err) else $error("encoder set the error flag");
  property p_byte_after_fmt;
    byte_wr && frame_in_q |-> have_fmt_q;
  endproperty
  a_byte_after_fmt: assert property (p_byte_after_fmt) else $error("frame byte before any format");
  property p_silence_byte;
    byte_wr && frame_in_q && (type_q == TYPE_SILENCE) |-> wdata[7:0] == SILENCE_BYTE;
  endproperty
  a_silence_byte: assert property (p_silence_byte) else $error("silence slot byte wrong");
  property p_no_excess;
    byte_wr && frame_in_q && (type_q != TYPE_SILENCE) |-> cnt_q < len_w;
  endproperty
  a_no_excess: assert property (p_no_excess) else $error("more bytes than the frame type allows");
  property p_frame_whole;
    fmt_wr && frame_in_q && have_fmt_q && (type_q != TYPE_SILENCE) |-> cnt_q == len_w;
  endproperty
  a_frame_whole: assert property (p_frame_whole) else $error("frame cut short");
  property p_bytes_follow_fmt;
    rd && (addr == ADDR_OUT_FMT) |=> rd && (addr == ADDR_OUT_BYTE);
  endproperty
  a_bytes_follow_fmt: assert property (p_bytes_follow_fmt) else $error("format read not followed by bytes");
endmodule

// *** stf_codec_end.sv ***
// Transcoder end: register file, sample companding and frame format handling.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps

// Overview of operation
// - Compand 8 kHz linear to 64 kbit/s bytes.
// - Mu-law maps 14-bit linear to 8 bits.
// - A-law maps 13-bit linear to 8 bits.
// - One sample in, one out, no memory.
// - A-law bytes XOR 0x55 both ways.
// - Mu-law bytes XOR 0xFF both ways.
// - Frames are 30 ms, 240 samples.
// - Encoder uses rate and suppression options.
// - Suppression: one descriptor, then silence only.
// - Descriptor frame starts comfort noise.
// - Decode by input type, encode by output.
// - Monitor samples optional, switchable off.
// - Duplex adds a reverse-direction channel.
// - Format byte: error bit 4, type 1:0.
// - Type lengths 24, 20, 4, 1 byte.
// - Host fills silence slots with byte 3.
// - Host writes format before frame bytes; in a silence run only the first frame gets one.
// - Error flag requests lost frame concealment.
// - Host writes exactly the implied length.
// - Host reads format then implied bytes.
// - Encoder never sets the error flag.
// - Typical latency 67 ms encode, 9.5 ms decode.
// - Each companded byte gives one 0.125 ms sample.
module stf_codec_end
  import stf_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  stf_bus_if.codec         bus,
  input  wire logic        adc_valid,
  input  wire logic [13:0] adc_sample,
  input  wire logic        voice_active,
  input  wire logic        enc_valid,
  input  wire logic [7:0]  enc_byte,
  input  wire logic [1:0]  enc_type,
  input  wire logic        enc_last,
  output logic             enc_ready,
  output logic             enc_rate_low,
  output logic             silence_suppression,
  output logic             dec_valid,
  output logic [7:0]       dec_byte,
  output logic [7:0]       dec_format,
  output logic             dec_frame_end,
  output logic             lost_frame_concealment,
  output logic             comfort_noise,
  output logic             core_lin_valid,
  output logic [13:0]      core_lin,
  output logic             mon_valid,
  output logic [13:0]      decoder_monitor_output,
  output logic             rev_valid,
  output logic [7:0]       rev_byte,
  output logic             out_frame_ready
);

  typedef struct packed {
    logic [15:0]                     rdata;
    logic [7:0]                      in_fmt;
    logic [15:0]                     in_sel;
    logic [15:0]                     out_sel;
    logic [15:0]                     opts;
    logic [4:0]                      in_cnt;
    logic                            dec_valid;
    logic [7:0]                      dec_byte;
    logic [7:0]                      dec_format;
    logic                            dec_end;
    logic                            conceal;
    logic                            comfort;
    logic                            lin_valid;
    logic                            mon_valid;
    logic [13:0]                     lin;
    logic                            rev_valid;
    logic [7:0]                      rev_byte;
    logic [FRAME_BUF_BYTES-1:0][7:0] buf_b;
    logic [7:0]                      out_fmt;
    logic [4:0]                      out_len;
    logic [4:0]                      out_idx;
    logic [4:0]                      wr_idx;
    logic                            out_busy;
    logic                            sid_sent;
    logic                            ready;
  } stf_codec_s;

  stf_codec_s q;
  stf_codec_s d;
  logic [7:0]  wbyte;
  logic [13:0] lin_s;
  logic [7:0]  enc_b;
  logic [1:0]  ftype;
  logic        quiet;

  always_comb begin
    d           = q;
    wbyte       = bus.wdata[7:0];
    lin_s       = 14'h0000;
    enc_b       = 8'h00;
    ftype       = enc_type;
    quiet       = q.opts[OPT_SUPPRESS_BIT] && !voice_active;
    d.rdata     = 16'h0000;
    d.dec_valid = 1'b0;
    d.dec_end   = 1'b0;
    d.lin_valid = 1'b0;
    d.mon_valid = 1'b0;
    d.rev_valid = 1'b0;
    if (bus.wr) begin
      if (bus.addr == ADDR_IN_FMT) begin
        d.in_fmt = wbyte & FMT_MASK;
        d.in_cnt = 5'h00;
      end else if (bus.addr == ADDR_IN_SEL) begin
        d.in_sel = bus.wdata;
      end else if (bus.addr == ADDR_OUT_SEL) begin
        d.out_sel = bus.wdata;
      end else if (bus.addr == ADDR_OPTS) begin
        d.opts = bus.wdata;
      end else if (bus.addr == ADDR_IN_BYTE) begin
        if (q.in_sel[1:0] == CODE_FRAME) begin
          d.dec_valid  = 1'b1;
          d.dec_byte   = wbyte;
          d.dec_format = q.in_fmt;
          d.in_cnt     = q.in_cnt + 5'h01;
          if (d.in_cnt == frame_len(q.in_fmt[1:0])) begin
            d.dec_end = 1'b1;
            d.in_cnt  = 5'h00;
            d.conceal = q.in_fmt[FMT_ERR_BIT];
            if (q.in_fmt[1:0] == TYPE_SID) d.comfort = 1'b1;
            else if (q.in_fmt[1:0] != TYPE_SILENCE) d.comfort = 1'b0;
          end
        end else begin
          if (q.in_sel[1:0] == CODE_MULAW) lin_s = mulaw_dec(wbyte ^ MULAW_XOR);
          else if (q.in_sel[1:0] == CODE_ALAW) lin_s = {alaw_dec(wbyte ^ ALAW_XOR), 1'b0};
          else lin_s = {wbyte, 6'h00};
          d.lin = lin_s;
          d.mon_valid = q.opts[OPT_MONITOR_BIT];
          if (q.out_sel[1:0] == CODE_FRAME) begin
            d.lin_valid = 1'b1;
          end else begin
            if (q.out_sel[1:0] == CODE_MULAW) enc_b = mulaw_enc(lin_s) ^ MULAW_XOR;
            else if (q.out_sel[1:0] == CODE_ALAW) enc_b = alaw_enc(lin_s[13:1]) ^ ALAW_XOR;
            else enc_b = lin_s[13:6];
            // A sample that finds the holding byte still unread is dropped.
            if (!q.out_busy) begin
              d.buf_b[0] = enc_b;
              d.out_len  = 5'h01;
              d.out_idx  = 5'h00;
              d.out_fmt  = 8'h00;
              d.out_busy = 1'b1;
            end
          end
        end
      end
    end
    if (bus.rd) begin
      if (bus.addr == ADDR_OUT_BYTE) begin
        if (q.out_busy) begin
          d.rdata = {8'h00, q.buf_b[q.out_idx]};
          if (q.out_idx + 5'h01 == q.out_len) d.out_busy = 1'b0;
          else d.out_idx = q.out_idx + 5'h01;
        end
      end else if (bus.addr == ADDR_OUT_FMT) begin
        d.rdata = {8'h00, q.out_fmt};
      end
    end
    if (enc_valid && q.ready && q.out_sel[1:0] == CODE_FRAME) begin
      d.buf_b[q.wr_idx] = enc_byte;
      d.wr_idx          = q.wr_idx + 5'h01;
      if (enc_last) begin
        if (quiet && q.sid_sent) begin
          ftype      = TYPE_SILENCE;
          d.buf_b[0] = SILENCE_BYTE;
        end
        d.sid_sent = quiet;
        d.out_fmt  = {6'h00, ftype};
        d.out_len  = frame_len(ftype);
        d.out_idx  = 5'h00;
        d.wr_idx   = 5'h00;
        d.out_busy = 1'b1;
      end
    end
    if (adc_valid && q.out_sel[SEL_DUPLEX_BIT]) begin
      d.rev_valid = 1'b1;
      if (q.in_sel[1:0] == CODE_MULAW) d.rev_byte = mulaw_enc(adc_sample) ^ MULAW_XOR;
      else if (q.in_sel[1:0] == CODE_ALAW) d.rev_byte = alaw_enc(adc_sample[13:1]) ^ ALAW_XOR;
      else d.rev_byte = adc_sample[13:6];
    end
    // Holding off the core while a frame waits keeps frames from overwriting each other.
    d.ready = !d.out_busy && (d.wr_idx != 5'(FRAME_BUF_BYTES) || !q.ready);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q         <= '0;
      q.in_sel  <= SEL_RESET;
      q.out_sel <= SEL_RESET;
      q.opts    <= OPTS_RESET;
      q.ready   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // latency belongs to the external coder core
  assign bus.rdata              = q.rdata;
  assign enc_ready              = q.ready;
  assign enc_rate_low           = q.opts[OPT_RATE_LOW_BIT];
  assign silence_suppression    = q.opts[OPT_SUPPRESS_BIT];
  assign dec_valid              = q.dec_valid;
  assign dec_byte               = q.dec_byte;
  assign dec_format             = q.dec_format;
  assign dec_frame_end          = q.dec_end;
  assign lost_frame_concealment = q.conceal;
  assign comfort_noise          = q.comfort;
  assign core_lin_valid         = q.lin_valid;
  assign core_lin               = q.lin;
  assign mon_valid              = q.mon_valid;
  assign decoder_monitor_output = q.mon_valid ? q.lin : 14'h0000;
  assign rev_valid              = q.rev_valid;
  assign rev_byte               = q.rev_byte;
  assign out_frame_ready        = q.out_busy;

endmodule

// *** stf_host_end.sv ***
// Host controller end: sends frames and configuration and fetches frames over the register bus.
`timescale 1ns/1ps
module stf_host_end
  import stf_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  stf_bus_if.host          bus,
  input  wire logic        cfg_valid,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [15:0] cfg_data,
  input  wire logic        tx_start,
  input  wire logic [1:0]  tx_type,
  input  wire logic        tx_err,
  input  wire logic        tx_byte_valid,
  input  wire logic [7:0]  tx_byte,
  input  wire logic        rx_poll,
  output logic             host_idle,
  output logic             tx_byte_ready,
  output logic             rx_valid,
  output logic [7:0]       rx_byte,
  output logic             rx_last,
  output logic [1:0]       rx_type
);

  typedef enum logic [2:0] {H_IDLE, H_TX_DATA, H_TX_SIL, H_RX_FMT, H_RX_LEN, H_RX_DATA} stf_hstate_e;

  typedef struct packed {
    stf_hstate_e st;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [4:0]  remain;
    logic        sil_run;
    logic        rx_valid;
    logic [7:0]  rx_byte;
    logic        rx_last;
    logic [1:0]  rx_type;
  } stf_host_s;

  stf_host_s q;
  stf_host_s d;

  always_comb begin
    d          = q;
    d.wr       = 1'b0;
    d.rd       = 1'b0;
    d.rx_valid = 1'b0;
    d.rx_last  = 1'b0;
    case (q.st)
      H_IDLE: begin
        if (tx_start) begin
          d.wr = 1'b1;
          if (tx_type == TYPE_SILENCE) begin
            if (!q.sil_run) begin
              d.addr  = ADDR_IN_FMT;
              d.wdata = {14'h0000, TYPE_SILENCE};
              d.st    = H_TX_SIL;
            end else begin
              d.addr  = ADDR_IN_BYTE;
              d.wdata = {8'h00, SILENCE_BYTE};
            end
            d.sil_run = 1'b1;
          end else begin
            d.addr    = ADDR_IN_FMT;
            d.wdata   = {11'h000, tx_err, 2'h0, tx_type};
            d.remain  = frame_len(tx_type);
            d.sil_run = 1'b0;
            d.st      = H_TX_DATA;
          end
        end else if (rx_poll) begin
          d.rd   = 1'b1;
          d.addr = ADDR_OUT_FMT;
          d.st   = H_RX_FMT;
        end else if (cfg_valid) begin
          d.wr    = 1'b1;
          d.addr  = cfg_addr;
          d.wdata = cfg_data;
        end
      end
      H_TX_SIL: begin
        d.wr    = 1'b1;
        d.addr  = ADDR_IN_BYTE;
        d.wdata = {8'h00, SILENCE_BYTE};
        d.st    = H_IDLE;
      end
      H_TX_DATA: begin
        if (tx_byte_valid) begin
          d.wr     = 1'b1;
          d.addr   = ADDR_IN_BYTE;
          d.wdata  = {8'h00, tx_byte};
          d.remain = q.remain - 5'h01;
          if (q.remain == 5'h01) d.st = H_IDLE;
        end
      end
      H_RX_FMT: begin
        // Every frame holds a byte, so one byte read may start before the format is back.
        d.rd   = 1'b1;
        d.addr = ADDR_OUT_BYTE;
        d.st   = H_RX_LEN;
      end
      H_RX_LEN: begin
        d.rx_type = bus.rdata[1:0];
        d.remain  = frame_len(bus.rdata[1:0]);
        d.rd      = frame_len(bus.rdata[1:0]) != 5'h01;
        d.st      = H_RX_DATA;
      end
      H_RX_DATA: begin
        // silence byte read but not passed on
        d.rx_valid = q.rx_type != TYPE_SILENCE;
        d.rx_byte  = bus.rdata[7:0];
        d.rx_last  = q.remain == 5'h01;
        d.remain   = q.remain - 5'h01;
        // One read stays in flight ahead of the byte taken here.
        d.rd       = q.remain > 5'h02;
        if (q.remain == 5'h01) begin
          d.st = H_IDLE;
        end
      end
      default: d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q    <= '0;
      q.st <= H_IDLE;
    end else begin
      q <= d;
    end
  end

  assign bus.addr      = q.addr;
  assign bus.wdata     = q.wdata;
  assign bus.wr        = q.wr;
  assign bus.rd        = q.rd;
  assign host_idle     = q.st == H_IDLE;
  assign tx_byte_ready = q.st == H_TX_DATA;
  assign rx_valid      = q.rx_valid;
  assign rx_byte       = q.rx_byte;
  assign rx_last       = q.rx_last;
  assign rx_type       = q.rx_type;

endmodule

// *** stf_pkg.sv ***
// Shared constants, register map, frame format and companding functions for the speech transcoder link.
package stf_pkg;

  localparam logic [7:0]  ADDR_IN_BYTE  = 8'h48;
  localparam logic [7:0]  ADDR_IN_FMT   = 8'h4A;
  localparam logic [7:0]  ADDR_OUT_BYTE = 8'h4C;
  localparam logic [7:0]  ADDR_OUT_FMT  = 8'h4E;
  localparam logic [7:0]  ADDR_IN_SEL   = 8'h54;
  localparam logic [7:0]  ADDR_OUT_SEL  = 8'h56;
  localparam logic [7:0]  ADDR_OPTS     = 8'h5E;

  // Coding select field, bits 1:0 of both coding select registers.
  localparam logic [1:0]  CODE_LINEAR   = 2'h0;
  localparam logic [1:0]  CODE_MULAW    = 2'h1;
  localparam logic [1:0]  CODE_ALAW     = 2'h2;
  localparam logic [1:0]  CODE_FRAME    = 2'h3;
  localparam int          SEL_DUPLEX_BIT = 8;
  localparam int          OPT_RATE_LOW_BIT = 0;
  localparam int          OPT_SUPPRESS_BIT = 1;
  localparam int          OPT_MONITOR_BIT  = 8;
  localparam logic [15:0] SEL_RESET     = 16'h0000;
  localparam logic [15:0] OPTS_RESET    = 16'h0000;

  // Per-frame format byte.
  localparam int          FMT_ERR_BIT   = 4;
  localparam logic [7:0]  FMT_MASK      = 8'h13;
  localparam logic [1:0]  TYPE_VOICE_HI = 2'h0;
  localparam logic [1:0]  TYPE_VOICE_LO = 2'h1;
  localparam logic [1:0]  TYPE_SID      = 2'h2;
  localparam logic [1:0]  TYPE_SILENCE  = 2'h3;
  localparam logic [4:0]  LEN_VOICE_HI  = 5'h18;
  localparam logic [4:0]  LEN_VOICE_LO  = 5'h14;
  localparam logic [4:0]  LEN_SID       = 5'h04;
  localparam logic [4:0]  LEN_SILENCE   = 5'h01;
  localparam logic [7:0]  SILENCE_BYTE  = 8'h03;
  localparam int          FRAME_BUF_BYTES = 24;

  localparam logic [7:0]  ALAW_XOR      = 8'h55;
  localparam logic [7:0]  MULAW_XOR     = 8'hFF;
  localparam logic [13:0] MULAW_CLIP    = 14'h1FDE;
  localparam logic [13:0] MULAW_BIAS    = 14'h0021;

  // Timing of the coded streams; the frame coder core outside this block works to these.
  localparam int          CLOCK_HZ        = 250000000;
  localparam int          SAMPLE_RATE_HZ  = 8000;
  localparam int          CODED_RATE_KBPS = 64;
  localparam int          SAMPLE_PERIOD_US_X1000 = 125;
  localparam int          FRAME_MS        = 30;
  localparam int          SAMPLES_PER_FRAME = 240;
  localparam int          ENC_LATENCY_US  = 67000;
  localparam int          DEC_LATENCY_US  = 9500;

  function automatic logic [4:0] frame_len(input logic [1:0] t);
    frame_len = (t == TYPE_VOICE_HI) ? LEN_VOICE_HI : (t == TYPE_VOICE_LO) ? LEN_VOICE_LO :
                (t == TYPE_SID) ? LEN_SID : LEN_SILENCE;
  endfunction

  function automatic logic [7:0] mulaw_enc(input logic [13:0] s);
    logic [13:0] m;
    logic [2:0]  seg;
    m   = s[13] ? 14'(-s) : s;
    if (m > MULAW_CLIP) m = MULAW_CLIP;
    m   = m + MULAW_BIAS;
    seg = 3'h0;
    for (int i = 0; i < 8; i++) if (m[i + 5]) seg = 3'(i);
    mulaw_enc = {s[13], seg, 4'(m >> (4'(seg) + 4'h1))};
  endfunction

  function automatic logic [13:0] mulaw_dec(input logic [7:0] c);
    logic [13:0] mag;
    mag = 14'((({10'h000, c[3:0]} << 1) + MULAW_BIAS) << c[6:4]) - MULAW_BIAS;
    mulaw_dec = c[7] ? 14'(-mag) : mag;
  endfunction

  function automatic logic [7:0] alaw_enc(input logic [12:0] s);
    logic [11:0] m;
    logic [2:0]  seg;
    m   = s[12] ? ~s[11:0] : s[11:0];
    seg = 3'h0;
    for (int i = 1; i < 8; i++) if (m[i + 4]) seg = 3'(i);
    alaw_enc = {~s[12], seg, (seg == 3'h0) ? m[4:1] : 4'(m >> seg)};
  endfunction

  function automatic logic [12:0] alaw_dec(input logic [7:0] c);
    logic [11:0] mag;
    if (c[6:4] == 3'h0) mag = {7'h00, c[3:0], 1'b1};
    else mag = 12'((({8'h00, c[3:0]} << 1) + 12'h021) << (c[6:4] - 3'h1));
    alaw_dec = c[7] ? {1'b0, mag} : ~{1'b0, mag};
  endfunction

endpackage

// *** tb_speech_transcoder_framing.sv ***
// Self-checking bench joining the host end and the transcoder end over the register bus.
`timescale 1ns/1ps
module tb_speech_transcoder_framing
  import stf_pkg::*;
;
  logic clock = 1'b0, rst_n = 1'b0;
  logic adc_valid = 1'b0, voice_active = 1'b1, enc_valid = 1'b0, enc_last = 1'b0;
  logic [13:0] adc_sample = 14'h0000;
  logic [7:0] enc_byte = 8'h00, cfg_addr = 8'h00, tx_byte = 8'h00;
  logic [1:0] enc_type = 2'h0, tx_type = 2'h0;
  logic cfg_valid = 1'b0, tx_start = 1'b0, tx_err = 1'b0, tx_byte_valid = 1'b0, rx_poll = 1'b0;
  logic [15:0] cfg_data = 16'h0000;
  logic enc_ready, enc_rate_low, silence_suppression, dec_valid, dec_frame_end, lost_frame_concealment;
  logic comfort_noise, mon_valid, rev_valid, out_frame_ready, host_idle, tx_byte_ready, rx_valid, rx_last;
  logic [7:0] dec_byte, dec_format, rev_byte, rx_byte, dec_fmt_seen;
  logic [1:0] rx_type;
  logic [7:0] dec_q[$], rx_q[$];
  int bad_count = 0, comparisons = 0, cycles = 0, mon_n = 0, rev_n = 0, k;
  logic [1:0] dt [5] = '{TYPE_SID, TYPE_SILENCE, TYPE_SILENCE, TYPE_VOICE_HI, TYPE_VOICE_LO};
  logic de [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic dc [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  int dn [5] = '{4, 1, 1, 24, 20};
  logic [1:0] et [7] = '{TYPE_VOICE_LO, TYPE_VOICE_HI, TYPE_SID, TYPE_SILENCE, TYPE_SID, TYPE_VOICE_HI, TYPE_VOICE_HI};
  logic [1:0] rt [7] = '{TYPE_VOICE_LO, TYPE_VOICE_HI, TYPE_SID, TYPE_SILENCE, TYPE_SID, TYPE_SILENCE, TYPE_VOICE_HI};
  int en [7] = '{20, 24, 4, 1, 4, 24, 24};
  int rn [7] = '{20, 24, 4, 0, 4, 0, 24};
  logic va [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [1:0] as [7] = '{CODE_MULAW, CODE_MULAW, CODE_MULAW, CODE_ALAW, CODE_ALAW, CODE_ALAW, CODE_LINEAR};
  logic [13:0] ai [7] = '{14'h0000, 14'h1FFF, 14'h3FFF, 14'h0000, 14'h3FFF, 14'h1FFE, 14'h2A5C};
  logic [7:0] ao [7] = '{8'hFF, 8'h80, 8'h7E, 8'hD5, 8'h55, 8'hAA, 8'hA9};

  stf_bus_if bus_if();
  stf_codec_end i_stf_codec_end(.clock(clock), .rst_n(rst_n), .bus(bus_if), .adc_valid(adc_valid),
    .adc_sample(adc_sample), .voice_active(voice_active), .enc_valid(enc_valid), .enc_byte(enc_byte),
    .enc_type(enc_type), .enc_last(enc_last), .enc_ready(enc_ready), .enc_rate_low(enc_rate_low),
    .silence_suppression(silence_suppression), .dec_valid(dec_valid), .dec_byte(dec_byte),
    .dec_format(dec_format), .dec_frame_end(dec_frame_end), .lost_frame_concealment(lost_frame_concealment),
    .comfort_noise(comfort_noise), .core_lin_valid(), .core_lin(), .mon_valid(mon_valid),
    .decoder_monitor_output(), .rev_valid(rev_valid), .rev_byte(rev_byte), .out_frame_ready(out_frame_ready));
  stf_host_end i_stf_host_end(.clock(clock), .rst_n(rst_n), .bus(bus_if), .cfg_valid(cfg_valid),
    .cfg_addr(cfg_addr), .cfg_data(cfg_data), .tx_start(tx_start), .tx_type(tx_type), .tx_err(tx_err),
    .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte), .rx_poll(rx_poll), .host_idle(host_idle),
    .tx_byte_ready(tx_byte_ready), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last), .rx_type(rx_type));
  stf_checker i_stf_checker(.clock(clock), .rst_n(rst_n), .addr(bus_if.addr), .wdata(bus_if.wdata),
    .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata));

  always #2 clock = ~clock;

  // Collectors sample at the edge, so they see the value that stood in the cycle before it.
  always @(posedge clock) begin
    cycles++;
    if (dec_valid === 1'b1) begin
      dec_q.push_back(dec_byte);
      dec_fmt_seen = dec_format;
    end
    if (rx_valid === 1'b1) rx_q.push_back(rx_byte);
    if (mon_valid === 1'b1) mon_n++;
    if (rev_valid === 1'b1) rev_n++;
    if (cycles == 30000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    @(negedge clock);
    while (host_idle !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
  endtask

  task automatic cfg_write(input logic [7:0] a, input logic [15:0] d);
    wait_idle();
    @(posedge clock);
    cfg_valid <= 1'b1;
    cfg_addr <= a;
    cfg_data <= d;
    @(posedge clock);
    cfg_valid <= 1'b0;
    repeat (2) @(posedge clock);
    wait_idle();
  endtask

  task automatic send_frame(input logic [1:0] t, input logic e, input int n);
    int w;
    wait_idle();
    @(posedge clock);
    tx_start <= 1'b1;
    tx_type <= t;
    tx_err <= e;
    @(posedge clock);
    tx_start <= 1'b0;
    for (int i = 0; i < n && t != TYPE_SILENCE; i++) begin
      tx_byte_valid <= 1'b1;
      tx_byte <= 8'(8'hA0 + i);
      w = 0;
      @(negedge clock);
      while (tx_byte_ready !== 1'b1 && w < 100) begin @(negedge clock); w++; end
      @(posedge clock);
    end
    tx_byte_valid <= 1'b0;
    repeat (3) @(posedge clock);
    wait_idle();
  endtask

  task automatic enc_frame(input logic [1:0] t, input int n);
    int w;
    w = 0;
    @(negedge clock);
    while (enc_ready !== 1'b1 && w < 200) begin @(negedge clock); w++; end
    @(posedge clock);
    for (int i = 0; i < n; i++) begin
      enc_valid <= 1'b1;
      enc_byte <= 8'(8'h40 + i);
      enc_type <= t;
      enc_last <= (i == n - 1);
      w = 0;
      @(negedge clock);
      while (enc_ready !== 1'b1 && w < 100) begin @(negedge clock); w++; end
      @(posedge clock);
    end
    enc_valid <= 1'b0;
    enc_last <= 1'b0;
    @(negedge clock);
    check("frame waiting", out_frame_ready, 16'h0001);
    check("core held off", enc_ready, 16'h0000);
  endtask

  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    check("reset enc_ready", enc_ready, 16'h0001);
    check("reset rate", enc_rate_low, 16'h0000);
    check("reset frame ready", out_frame_ready, 16'h0000);
    $display("test reset done");
    cfg_write(ADDR_IN_SEL, 16'h0003);
    for (int i = 0; i < 5; i++) begin
      dec_q.delete();
      send_frame(dt[i], de[i], dn[i]);
      check("dec count", 16'(dec_q.size()), 16'(dn[i]));
      foreach (dec_q[j]) check("dec byte", dec_q[j], (dt[i] == TYPE_SILENCE) ? 16'h0003 : 16'(8'hA0 + j));
      check("dec format", dec_fmt_seen, {3'b000, de[i], 2'b00, dt[i]});
      check("concealment", lost_frame_concealment, de[i]);
      check("comfort noise", comfort_noise, dc[i]);
    end
    check("monitor off", 16'(mon_n), 16'h0000);
    $display("test frame decode done");
    cfg_write(ADDR_OUT_SEL, 16'h0003);
    for (int i = 0; i < 7; i++) begin
      if (i == 4) begin
        cfg_write(ADDR_OPTS, 16'h0003);
        check("rate option", enc_rate_low, 16'h0001);
        check("suppress option", silence_suppression, 16'h0001);
      end
      @(posedge clock);
      voice_active <= va[i];
      enc_frame(et[i], en[i]);
      rx_q.delete();
      wait_idle();
      @(posedge clock);
      rx_poll <= 1'b1;
      @(posedge clock);
      rx_poll <= 1'b0;
      repeat (2) @(posedge clock);
      wait_idle();
      @(negedge clock);
      check("rx type", rx_type, rt[i]);
      check("rx count", 16'(rx_q.size()), 16'(rn[i]));
      foreach (rx_q[j]) check("rx byte", rx_q[j], 16'(8'h40 + j));
      check("frame drained", out_frame_ready, 16'h0000);
    end
    $display("test frame encode done");
    k = rev_n;
    @(posedge clock);
    adc_valid <= 1'b1;
    @(posedge clock);
    adc_valid <= 1'b0;
    repeat (20) @(posedge clock);
    check("no reverse in simplex", 16'(rev_n - k), 16'h0000);
    cfg_write(ADDR_OUT_SEL, 16'h0100);
    for (int i = 0; i < 7; i++) begin
      cfg_write(ADDR_IN_SEL, {14'h0000, as[i]});
      k = rev_n;
      @(posedge clock);
      adc_valid <= 1'b1;
      adc_sample <= ai[i];
      @(posedge clock);
      adc_valid <= 1'b0;
      repeat (20) @(posedge clock);
      check("reverse count", 16'(rev_n - k), 16'h0001);
      check("reverse byte", rev_byte, ao[i]);
    end
    cfg_write(ADDR_OPTS, 16'h0100);
    cfg_write(ADDR_IN_BYTE, 16'h00FF);
    check("monitor on", 16'(mon_n), 16'h0001);
    check("one byte out", out_frame_ready, 16'h0001);
    $display("test companding done");
    summarize();
  end
endmodule
